// ### rtl/sfrcb_pkg.sv
/*
 * Package for the special function register control bank: register byte
 * addresses, field positions, reset values, pin drive codes and carriers.
 * Assumes a 32-bit AXI4-Lite register bus; each register is one word.
 */
package sfrcb_pkg;

    // Register byte addresses
    localparam logic [7:0] SFRCB_P1A_ADDR  = 8'h00; // Port 1 config A
    localparam logic [7:0] SFRCB_P1B_ADDR  = 8'h04; // Port 1 config B
    localparam logic [7:0] SFRCB_P2A_ADDR  = 8'h08; // Port 2 config A
    localparam logic [7:0] SFRCB_P2B_ADDR  = 8'h0c; // Port 2 config B
    localparam logic [7:0] SFRCB_P3A_ADDR  = 8'h10; // Port 3 config A
    localparam logic [7:0] SFRCB_P3B_ADDR  = 8'h14; // Port 3 config B
    localparam logic [7:0] SFRCB_POWER_CONTROL_ADDR = 8'h18; // Power control
    localparam logic [7:0] SFRCB_PSW_ADDR  = 8'h1c; // Status word
    localparam logic [7:0] SFRCB_PWM_BASE  = 8'h20; // Pulse control 0
    localparam logic [7:0] SFRCB_PWM_LAST  = 8'h30; // Pulse control 4
    localparam int         SFRCB_ADDR_W    = 8;     // Decoded address bits

    // Power control fields
    localparam int SFRCB_PC_AUXOFF = 7; // Aux RAM off
    localparam int SFRCB_PC_QUIET  = 6; // Emission quiet
    localparam int SFRCB_PC_WDOG   = 4; // Watchdog on
    localparam int SFRCB_PC_UF1    = 3; // User flag one
    localparam int SFRCB_PC_UF0    = 2; // User flag zero
    localparam int SFRCB_PC_SLEEP  = 1; // Deep sleep request
    localparam int SFRCB_PC_HALT   = 0; // Cpu halt request

    // Status word fields (bank select at 4:3)
    localparam int SFRCB_PSW_BS_LO = 3; // Bank select low bit
    localparam int SFRCB_BANK_SH   = 3; // Bank base = select times eight

    // Pulse control fields
    localparam int SFRCB_PW_ON     = 7; // Pulse enable bit
    localparam int SFRCB_PW_HT_W   = 6; // High time width

    // Reset values
    localparam logic [7:0] SFRCB_CFG_RST  = 8'hff; // Quasi-bidirectional
    localparam logic [7:0] SFRCB_ZERO_RST = 8'h00; // Other registers

    // AXI responses
    localparam logic [1:0] SFRCB_RESP_OK  = 2'h0; // OKAY
    localparam logic [1:0] SFRCB_RESP_ERR = 2'h2; // SLVERR

    // Pin drive codes, B bit over A bit
    typedef enum logic [1:0] {
        SFRCB_OPEN_DRAIN = 2'h0,
        SFRCB_QUASI_BIDI = 2'h1,
        SFRCB_HIGH_Z     = 2'h2,
        SFRCB_PUSH_PULL  = 2'h3
    } sfrcb_drive_t;

    // Per-port drive code vector
    typedef struct packed {
        sfrcb_drive_t [7:0] pin;
    } sfrcb_port_mode_t;

    // Power control steering outputs
    typedef struct packed {
        logic aux_ram_off;
        logic emission_quiet;
        logic watchdog_on;
        logic deep_sleep_request;
        logic cpu_halt_request;
    } sfrcb_power_t;

endpackage : sfrcb_pkg

// ### rtl/sfrcb_pwm.sv
/*
 * One pulse width channel: 64-step period, high for the programmed count.
 * Assumes the enable and high time come from the register bank registers.
 */
`timescale 1ns/100ps
`default_nettype none
module sfrcb_pwm #(
    parameter int HT_W = 6                   // High time width
) (
    input  wire logic            aclk,       // Core clock
    input  wire logic            aresetn,    // Sync reset, active low
    input  wire logic            enable,     // Channel enable
    input  wire logic [HT_W-1:0] high_time,  // High steps per period
    output logic                 pwm_out     // Registered pulse output
);
    import sfrcb_pkg::*;

    // All channel state in one struct
    typedef struct packed {
        logic [HT_W-1:0] step;
        logic            out;
    } sfrcb_pwm_st_t;

    sfrcb_pwm_st_t st_r;  // Registered state
    sfrcb_pwm_st_t st_nxt; // Next state

    // Counter wraps every 2**HT_W steps; output high while step < value
    always_comb begin
        st_nxt = st_r;
        if (!enable) begin                       // Idle, counter parked [RULE_10]
            st_nxt.step = '0;
            st_nxt.out  = 1'b0;
        end else begin
            st_nxt.step = st_r.step + 1'b1;      // [RULE_14]
            st_nxt.out  = (st_r.step < high_time); // [RULE_11]
        end
    end

    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pwm_out = st_r.out;

    // A disabled channel is low two cycles later
    off_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !enable ##1 !enable |=> !pwm_out) // [RULE_10]
        else $error("Disabled channel still drives high");

    // Zero high time never drives high
    zero_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $stable(high_time) && high_time == '0 && enable |=> !pwm_out) // [RULE_14]
        else $error("Zero high time gave high output");

endmodule : sfrcb_pwm
`default_nettype wire

// ### rtl/sfrcb_bank.sv
/*
 * Special function register control bank: port drive config for ports
 * 1 to 3, power control, status word bank select and five pulse channels.
 * Assumes an AXI4-Lite master on aclk; steered units sit outside.
 */
// Design decisions made here: register access over AXI4-Lite and the register offsets.
// What this block does
// RULE_01 - Pin config from B bit and A bit
// RULE_02 - Codes: open-drain, quasi, high-Z, push-pull
// RULE_03 - Aux RAM off sends moves external
// RULE_04 - Emission quiet hides strobe on internal access
// RULE_05 - Deep sleep bit enters power-down
// RULE_06 - Halt bit enters idle mode
// RULE_07 - Two free user flag bits
// RULE_08 - Bank select maps working register base
// RULE_09 - Channel 0 enable takes its port pin
// RULE_10 - Channels 1-4 run only when enabled
// RULE_11 - Six-bit high time field per channel
// RULE_12 - Port 1 uses the same scheme
// RULE_13 - Disabled channel leaves pin to port
// RULE_14 - Period 64 steps, high for field
`timescale 1ns/100ps
`default_nettype none
module sfrcb_bank
    import sfrcb_pkg::*;
#(
    parameter int NPWM = 5                          // Pulse channels
) (
    input  wire logic                    aclk,          // Core clock
    input  wire logic                    aresetn,       // Sync reset
    input  wire logic [7:0]              s_axi_awaddr,  // Write address
    input  wire logic                    s_axi_awvalid, // Write addr valid
    output logic                         s_axi_awready, // Write addr ready
    input  wire logic [31:0]             s_axi_wdata,   // Write data
    input  wire logic [3:0]              s_axi_wstrb,   // Byte strobes
    input  wire logic                    s_axi_wvalid,  // Write data valid
    output logic                         s_axi_wready,  // Write data ready
    output logic [1:0]                   s_axi_bresp,   // Write response
    output logic                         s_axi_bvalid,  // Write resp valid
    input  wire logic                    s_axi_bready,  // Write resp ready
    input  wire logic [7:0]              s_axi_araddr,  // Read address
    input  wire logic                    s_axi_arvalid, // Read addr valid
    output logic                         s_axi_arready, // Read addr ready
    output logic [31:0]                  s_axi_rdata,   // Read data
    output logic [1:0]                   s_axi_rresp,   // Read response
    output logic                         s_axi_rvalid,  // Read data valid
    input  wire logic                    s_axi_rready,  // Read data ready
    input  wire logic                    internal_access, // Cycle is on-chip
    input  wire logic                    strobe_req,    // Core address strobe
    output logic                         addr_strobe,   // Strobe to pin
    output logic                         external_data_move_to_external, // Move goes off-chip
    output sfrcb_pkg::sfrcb_power_t      power_out,     // Power steering
    output logic [4:0]                   bank_base,     // Working reg base
    output sfrcb_pkg::sfrcb_port_mode_t  port1_mode,    // Port 1 drive codes
    output sfrcb_pkg::sfrcb_port_mode_t  port2_mode,    // Port 2 drive codes
    output sfrcb_pkg::sfrcb_port_mode_t  port3_mode,    // Port 3 drive codes
    output logic                         pulse_ctrl_0_owns_pin, // Channel 0 has pin
    output logic [NPWM-1:0]              pwm_out        // Channel outputs
);

    // Whole bank state in one struct
    typedef struct packed {
        logic [7:0]            p1a, p1b, p2a, p2b, p3a, p3b; // Port config
        logic [7:0]            power_control;     // Power control
        logic [7:0]            status_word;      // Status word
        logic [NPWM-1:0][7:0]  pwm;      // Pulse control
        logic                  aw_hold;  // Write address captured
        logic [7:0]            aw_addr;  // Captured write address
        logic                  w_hold;   // Write data captured
        logic [31:0]           w_data;   // Captured write data
        logic [3:0]            w_strb;   // Captured strobes
        logic                  bvalid;   // Write response pending
        logic [1:0]            bresp;    // Write response code
        logic                  rvalid;   // Read data pending
        logic [1:0]            rresp;    // Read response code
        logic [31:0]           rdata;    // Read data
    } sfrcb_bank_st_t;

    sfrcb_bank_st_t st_r;   // Registered state
    sfrcb_bank_st_t st_nxt; // Next state

    // Map two config bytes onto per-pin drive codes
    function automatic sfrcb_port_mode_t drive_map(input logic [7:0] a,
                                                   input logic [7:0] b);
        sfrcb_port_mode_t m;
        m = '0;
        for (int i = 0; i < 8; i++) begin
            m.pin[i] = sfrcb_drive_t'({b[i], a[i]}); // [RULE_01] [RULE_02]
        end
        return m;
    endfunction : drive_map

    // Is this a mapped register address
    function automatic logic addr_hit(input logic [7:0] ad);
        return (ad[1:0] == 2'h0) && (ad <= SFRCB_PWM_LAST);
    endfunction : addr_hit

    // Merge write data byte 0 into a register
    function automatic logic [7:0] merge(input logic [7:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
        return s[0] ? d[7:0] : old;
    endfunction : merge

    // Read mux; bits above the byte read as zero
    function automatic logic [31:0] read_reg(input sfrcb_bank_st_t s,
                                             input logic [7:0] ad);
        logic [7:0] v;
        v = 8'h00;
        case (ad)
            SFRCB_P1A_ADDR:  v = s.p1a;
            SFRCB_P1B_ADDR:  v = s.p1b;
            SFRCB_P2A_ADDR:  v = s.p2a;
            SFRCB_P2B_ADDR:  v = s.p2b;
            SFRCB_P3A_ADDR:  v = s.p3a;
            SFRCB_P3B_ADDR:  v = s.p3b;
            SFRCB_POWER_CONTROL_ADDR: v = s.power_control; // User flags read back [RULE_07]
            SFRCB_PSW_ADDR:  v = s.status_word;
            default: begin
                for (int k = 0; k < NPWM; k++) begin
                    if (ad == SFRCB_PWM_BASE + 8'(4 * k)) begin
                        v = s.pwm[k];
                    end
                end
            end
        endcase
        return {24'h000000, v};
    endfunction : read_reg

    logic       do_write; // Both halves of a write are held
    logic [7:0] wa;       // Effective write address

    // Next-state logic: AXI handshakes and register writes
    always_comb begin
        st_nxt   = st_r;
        do_write = 1'b0;
        wa       = st_r.aw_addr;
        // Address and data taken in either order
        if (s_axi_awvalid && !st_r.aw_hold) begin
            st_nxt.aw_hold = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_r.w_hold) begin
            st_nxt.w_hold = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        // Commit once both are held and no response is pending
        if (st_r.aw_hold && st_r.w_hold && !st_r.bvalid) begin
            do_write       = 1'b1;
            st_nxt.aw_hold = 1'b0;
            st_nxt.w_hold  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = addr_hit(wa) ? SFRCB_RESP_OK : SFRCB_RESP_ERR;
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end
        if (do_write) begin
            case (wa)
                SFRCB_P1A_ADDR:  st_nxt.p1a  = merge(st_r.p1a, st_r.w_data,
                                                     st_r.w_strb);
                SFRCB_P1B_ADDR:  st_nxt.p1b  = merge(st_r.p1b, st_r.w_data,
                                                     st_r.w_strb);
                SFRCB_P2A_ADDR:  st_nxt.p2a  = merge(st_r.p2a, st_r.w_data,
                                                     st_r.w_strb);
                SFRCB_P2B_ADDR:  st_nxt.p2b  = merge(st_r.p2b, st_r.w_data,
                                                     st_r.w_strb);
                SFRCB_P3A_ADDR:  st_nxt.p3a  = merge(st_r.p3a, st_r.w_data,
                                                     st_r.w_strb);
                SFRCB_P3B_ADDR:  st_nxt.p3b  = merge(st_r.p3b, st_r.w_data,
                                                     st_r.w_strb);
                SFRCB_POWER_CONTROL_ADDR: st_nxt.power_control = merge(st_r.power_control, st_r.w_data,
                                                     st_r.w_strb); // [RULE_07]
                SFRCB_PSW_ADDR:  st_nxt.status_word  = merge(st_r.status_word, st_r.w_data,
                                                     st_r.w_strb);
                default: begin
                    for (int k = 0; k < NPWM; k++) begin
                        if (wa == SFRCB_PWM_BASE + 8'(4 * k)) begin
                            st_nxt.pwm[k] = merge(st_r.pwm[k], st_r.w_data,
                                                  st_r.w_strb);
                        end
                    end
                end
            endcase
        end
        // Read: one at a time, answered the cycle after the address
        if (s_axi_arvalid && !st_r.rvalid) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = read_reg(st_r, s_axi_araddr);
            st_nxt.rresp  = addr_hit(s_axi_araddr) ? SFRCB_RESP_OK
                                                   : SFRCB_RESP_ERR;
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
    end

    // State register; port config resets quasi-bidirectional
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r     <= '0;
            st_r.p1a <= SFRCB_CFG_RST;
            st_r.p2a <= SFRCB_CFG_RST;
            st_r.p3a <= SFRCB_CFG_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Bus outputs; ready while the capture slot is free
    assign s_axi_awready = !st_r.aw_hold;
    assign s_axi_wready  = !st_r.w_hold;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_rvalid  = st_r.rvalid;
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;

    // Port drive codes for all three ports
    assign port1_mode = drive_map(st_r.p1a, st_r.p1b); // [RULE_12]
    assign port2_mode = drive_map(st_r.p2a, st_r.p2b); // [RULE_01]
    assign port3_mode = drive_map(st_r.p3a, st_r.p3b); // [RULE_02]

    // Power steering bits straight from the register
    assign power_out.aux_ram_off        = st_r.power_control[SFRCB_PC_AUXOFF];
    assign power_out.emission_quiet     = st_r.power_control[SFRCB_PC_QUIET];
    assign power_out.watchdog_on        = st_r.power_control[SFRCB_PC_WDOG];
    assign power_out.deep_sleep_request = st_r.power_control[SFRCB_PC_SLEEP]; // [RULE_05]
    assign power_out.cpu_halt_request   = st_r.power_control[SFRCB_PC_HALT];  // [RULE_06]

    // Every external-data move goes off-chip when aux RAM is off
    assign external_data_move_to_external = st_r.power_control[SFRCB_PC_AUXOFF]; // [RULE_03]

    // Strobe gated on internal cycles while the quiet bit is set, to cut radiated noise
    assign addr_strobe = strobe_req &&
        !(st_r.power_control[SFRCB_PC_QUIET] && internal_access); // [RULE_04]

    // Bank base = select times eight: 00h, 08h, 10h, 18h
    assign bank_base = 5'(st_r.status_word[SFRCB_PSW_BS_LO +: 2]) << SFRCB_BANK_SH; // [RULE_08]

    // Channel 0 takes its pin only while enabled; else port keeps it
    assign pulse_ctrl_0_owns_pin = st_r.pwm[0][SFRCB_PW_ON]; // [RULE_09] [RULE_13]

    // Pulse channels
    for (genvar g = 0; g < NPWM; g++) begin : g_pwm
        sfrcb_pwm #(
            .HT_W      (SFRCB_PW_HT_W)
        ) u_pwm (
            .aclk      (aclk),
            .aresetn   (aresetn),
            .enable    (st_r.pwm[g][SFRCB_PW_ON]),          // [RULE_10]
            .high_time (st_r.pwm[g][SFRCB_PW_HT_W-1:0]),    // [RULE_11]
            .pwm_out   (pwm_out[g])
        );
    end

    // Strobe suppressed on quiet internal cycles
    quiet_strobe_a: assert property (@(posedge aclk) disable iff (!aresetn)
        power_out.emission_quiet && internal_access |-> !addr_strobe) // [RULE_04]
        else $error("Strobe active during quiet internal access");

    // Bank base follows the select field
    bank_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
        bank_base == {st_r.status_word[4:3], 3'h0}) // [RULE_08]
        else $error("Bank base does not match select");

    // Push-pull when both bits set on port 2 pin 0
    drive_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_r.p2a[0] && st_r.p2b[0] |-> port2_mode.pin[0] == SFRCB_PUSH_PULL) // [RULE_02]
        else $error("Drive code mismatch");

    // Write to power control shows on sleep output in the cycle the response is raised
    sleep_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && wa == SFRCB_POWER_CONTROL_ADDR && st_r.w_strb[0] |=>
        power_out.deep_sleep_request == $past(st_r.w_data[SFRCB_PC_SLEEP])) // [RULE_05]
        else $error("Sleep request did not follow write");

    // Read answer arrives the cycle after the address
    read_lat_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) // [RULE_07]
        else $error("Read answer late");

    // Aux RAM off tracks the register bit
    aux_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        external_data_move_to_external == power_out.aux_ram_off) // [RULE_03]
        else $error("Move routing mismatch");

    // Pin ownership follows channel 0 enable
    pin_own_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !st_r.pwm[0][SFRCB_PW_ON] |-> !pulse_ctrl_0_owns_pin) // [RULE_13]
        else $error("Pin held by disabled channel");

endmodule : sfrcb_bank
`default_nettype wire

// ### tb/sfrcb_bank_tb.sv
/*
 * Self-checking bench for the register control bank: table of register
 * accesses, then steering outputs, pulse channels and a mid-run reset.
 * Assumes the bank package and a single 20 MHz core clock.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
    fail_count++; $display("wrong value at %0t: got %h exp %h", \
    $time, (g), (e)); end end
module sfrcb_bank_tb;
    import sfrcb_pkg::*;
    typedef struct {
        logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;
    } sfrcb_row_t;                       // Address, write, read, response
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, internal_access, strobe_req;
    logic [7:0]  s_axi_awaddr, s_axi_araddr; // Byte addresses
    logic [31:0] s_axi_wdata, rd;             // Write data, read result
    logic [3:0]  s_axi_wstrb;                 // Byte strobes
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, addr_strobe, external_data_move_to_external, pulse_ctrl_0_owns_pin;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    logic [31:0] s_axi_rdata;
    logic [4:0]  bank_base, pwm_out;
    sfrcb_power_t     power_out;              // Power steering bits
    sfrcb_port_mode_t port1_mode, port2_mode, port3_mode;
    int fail_count = 0;
    int num_checks = 0;
    int bits [7] = '{0, 1, 2, 3, 4, 6, 7};    // Defined power bits
    int hts [5]  = '{1, 63, 0, 32, 20};       // High time per channel
    sfrcb_row_t rows [12] = '{
        '{SFRCB_P1A_ADDR, 32'h0000_00a5, 32'h0000_00a5, SFRCB_RESP_OK},
        '{SFRCB_P1B_ADDR, 32'hffff_ff3c, 32'h0000_003c, SFRCB_RESP_OK},
        '{SFRCB_P2A_ADDR, 32'h0000_000f, 32'h0000_000f, SFRCB_RESP_OK},
        '{SFRCB_P2B_ADDR, 32'h0000_0033, 32'h0000_0033, SFRCB_RESP_OK},
        '{SFRCB_P3A_ADDR, 32'h0000_0055, 32'h0000_0055, SFRCB_RESP_OK},
        '{SFRCB_P3B_ADDR, 32'h0000_00f0, 32'h0000_00f0, SFRCB_RESP_OK},
        '{SFRCB_POWER_CONTROL_ADDR, 32'h0000_000c, 32'h0000_000c, SFRCB_RESP_OK},
        '{SFRCB_PSW_ADDR, 32'h0000_0010, 32'h0000_0010, SFRCB_RESP_OK},
        '{SFRCB_PWM_BASE, 32'h0000_003f, 32'h0000_003f, SFRCB_RESP_OK},
        '{SFRCB_PWM_LAST, 32'h0000_002a, 32'h0000_002a, SFRCB_RESP_OK},
        '{8'h34, 32'hdead_beef, 32'h0000_0000, SFRCB_RESP_ERR},
        '{8'h06, 32'h0000_00ff, 32'h0000_0000, SFRCB_RESP_ERR}};

    sfrcb_bank i_sfrcb_bank (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .internal_access(internal_access), .strobe_req(strobe_req),
        .addr_strobe(addr_strobe), .external_data_move_to_external(external_data_move_to_external),
        .power_out(power_out), .bank_base(bank_base),
        .port1_mode(port1_mode), .port2_mode(port2_mode),
        .port3_mode(port3_mode), .pulse_ctrl_0_owns_pin(pulse_ctrl_0_owns_pin),
        .pwm_out(pwm_out));

    // Expected drive codes: B bit over A bit for each pin
    function automatic logic [15:0] pm(input logic [7:0] a,
                                       input logic [7:0] b);
        for (int i = 0; i < 8; i++) pm[2*i +: 2] = {b[i], a[i]};
    endfunction : pm

    // Verdict and end of run
    task automatic finish_test();
        if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    // Write: handshakes judged at the rising edge, released right after it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n; logic b;
        n = 0; b = 0;
        @(posedge aclk); // Gap so back-to-back calls never clash
        s_axi_awaddr <= a; s_axi_awvalid <= 1'b1; s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
        while (!b && n < 100) begin
            @(posedge aclk); n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            b = s_axi_bvalid;
            if (b) begin rr = s_axi_bresp; s_axi_bready <= 1'b0; end
        end
        if (!b) begin fail_count++; finish_test(); end
    endtask : wr

    // Read: data and response taken at the edge that sees rvalid
    task automatic rdr(input logic [7:0] a);
        int n; logic r;
        n = 0; r = 0;
        @(posedge aclk); // Gap so back-to-back calls never clash
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        while (!r && n < 100) begin
            @(posedge aclk); n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            r = s_axi_rvalid;
            if (r) begin
                rd = s_axi_rdata; rr = s_axi_rresp; s_axi_rready <= 1'b0;
            end
        end
        if (!r) begin fail_count++; finish_test(); end
    endtask : rdr

    // Program a channel, let it settle, count high cycles in one period
    task automatic pwm_run(input int ch, input logic [7:0] v, input int e);
        int hi;
        hi = 0;
        wr(SFRCB_PWM_BASE + 8'(4 * ch), {24'h0, v});
        repeat (70) @(posedge aclk);
        repeat (64) begin
            @(negedge aclk);
            if (pwm_out[ch] === 1'b1) hi++;
            else if (pwm_out[ch] !== 1'b0) hi += 1000; // Unknown output
        end
        @(posedge aclk);
        `CHK(hi, e)
    endtask : pwm_run

    // Core clock, 50 ns period
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (30000) @(posedge aclk);
        fail_count++;
        finish_test();
    end

    // Main sequence
    initial begin
        aresetn = 1'b0; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
        s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00; s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf; internal_access = 1'b0; strobe_req = 1'b1;
        repeat (10) @(posedge aclk);
        `CHK(port1_mode, 16'h5555)
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            `CHK(rr, rows[i].r)
        end
        foreach (rows[i]) begin
            rdr(rows[i].a);
            `CHK({rr, rd}, {rows[i].r, rows[i].q})
        end
        `CHK(port1_mode, pm(8'ha5, 8'h3c))
        `CHK(port2_mode, pm(8'h0f, 8'h33))
        `CHK(port3_mode, pm(8'h55, 8'hf0))
        // One power bit at a time, so a swapped field shows up
        foreach (bits[i]) begin
            wr(SFRCB_POWER_CONTROL_ADDR, 32'(1) << bits[i]);
            rd = 32'(1) << bits[i];
            `CHK(5'(power_out), {rd[7], rd[6], rd[4], rd[1], rd[0]})
            `CHK(external_data_move_to_external, rd[7])
        end
        // Strobe gating in all four quiet/internal combinations
        for (int k = 0; k < 4; k++) begin
            wr(SFRCB_POWER_CONTROL_ADDR, k[1] ? 32'h40 : 32'h0);
            internal_access <= k[0];
            @(negedge aclk);
            `CHK(addr_strobe, !(k[1] && k[0]))
        end
        for (int k = 0; k < 4; k++) begin
            wr(SFRCB_PSW_ADDR, 32'(k) << 3);
            `CHK(bank_base, 5'(8 * k))
        end
        for (int ch = 0; ch < 5; ch++) begin
            pwm_run(ch, 8'h80 | 8'(hts[ch]), hts[ch]);
            if (ch == 0) `CHK(pulse_ctrl_0_owns_pin, 1'b1)
            pwm_run(ch, 8'h3f, 0);
            if (ch == 0) `CHK(pulse_ctrl_0_owns_pin, 1'b0)
        end
        // Reset in mid-run brings back the defaults
        wr(SFRCB_PWM_BASE, 32'h0000_00a0);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        `CHK({5'(power_out), pwm_out, pulse_ctrl_0_owns_pin}, 11'h0)
        aresetn <= 1'b1;
        rdr(SFRCB_P1A_ADDR);
        `CHK(rd, 32'h0000_00ff)
        `CHK(port2_mode, 16'h5555)
        finish_test();
    end
endmodule : sfrcb_bank_tb
`default_nettype wire
